// ### fpem_defines.svh
// Purpose: constants for the fpu exception control, feature and mode block
// Assumes: 32-bit classic wishbone register bus, byte addresses
// Notes: field values of the feature registers are fixed by hardware
`ifndef FPEM_DEFINES_SVH
`define FPEM_DEFINES_SVH

`define FPEM_ADDR_EXC 4'h0
`define FPEM_ADDR_FEAT0 4'h4
`define FPEM_ADDR_FEAT1 4'h8
`define FPEM_ADDR_STAT 4'hC

`define FPEM_EXC_EN 30
`define FPEM_EXC_VUNDEF 29
`define FPEM_STAT_DNAN 25
`define FPEM_STAT_FZ 24
`define FPEM_STAT_IDC 7
`define FPEM_STAT_UFC 3
`define FPEM_STAT_IOC 0

`define FPEM_FEAT0_VAL 32'h1011_0201
`define FPEM_FEAT1_VAL 32'h0000_0011

`define FPEM_DNAN_SGL 32'h7FC0_0000
`define FPEM_DNAN_DBL 64'h7FF8_0000_0000_0000

`endif

// ### fpem_pkg.sv
// Purpose: types for the fpu exception control, feature and mode block
// Assumes: single operands sit in bits 31:0, upper half ignored
// Notes: none
package fpem_pkg;

    // instruction issued by the core pipeline
    typedef struct packed {
        logic sysreg;
        logic vector;
        logic arith;
        logic dbl;
        logic [63:0] op_a;
        logic [63:0] op_b;
    } fpem_issue_t;

    // raw datapath result before mode rewriting
    typedef struct packed {
        logic dbl;
        logic arith;
        logic tiny;
        logic nan_in;
        logic [63:0] value;
    } fpem_result_t;

    // conditioned operands to the datapath
    typedef struct packed {
        logic dbl;
        logic arith;
        logic [63:0] op_a;
        logic [63:0] op_b;
    } fpem_operands_t;

endpackage : fpem_pkg

// ### fpem_top.sv
// Purpose: exception control, feature registers and flush/default-nan mode logic
// Assumes: priv and all issue/result inputs are on clk; wishbone classic slave
// Notes: nonprivileged access to privileged registers answers with err_o
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "fpem_defines.svh"

module fpem_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    input wire logic priv,
    input wire logic issue_valid,
    input wire fpem_pkg::fpem_issue_t issue,
    output logic undef_exc,
    output logic ops_valid,
    output fpem_pkg::fpem_operands_t ops,
    input wire logic res_valid,
    input wire fpem_pkg::fpem_result_t res,
    output logic out_valid,
    output logic [63:0] out_value,
    output logic fp_enable,
    output logic flush_zero_bit,
    output logic default_nan_bit
);

    // ----------------------------------------------------------------
    // float classification
    // ----------------------------------------------------------------
    function automatic logic f_sub(input logic dbl, input logic [63:0] x);
        if (dbl) begin
            f_sub = (x[62:52] == 11'h000) && (x[51:0] != 52'h0);
        end else begin
            f_sub = (x[30:23] == 8'h00) && (x[22:0] != 23'h0);
        end
    endfunction

    function automatic logic f_nan(input logic dbl, input logic [63:0] x);
        if (dbl) begin
            f_nan = (x[62:52] == 11'h7FF) && (x[51:0] != 52'h0);
        end else begin
            f_nan = (x[30:23] == 8'hFF) && (x[22:0] != 23'h0);
        end
    endfunction

    function automatic logic f_snan(input logic dbl, input logic [63:0] x);
        f_snan = f_nan(dbl, x) && !(dbl ? x[51] : x[22]);
    endfunction

    function automatic logic [63:0] f_zero(input logic dbl, input logic [63:0] x);
        if (dbl) begin
            f_zero = {x[63], 63'h0};
        end else begin
            f_zero = {32'h0, x[31], 31'h0};
        end
    endfunction

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic exc_en;
    logic exc_vundef;
    logic fz;
    logic dn;
    logic flag_idc;
    logic flag_ufc;
    logic flag_ioc;

    // ----------------------------------------------------------------
    // wishbone decode
    // ----------------------------------------------------------------
    wire bus_req = cyc_i && stb_i;
    wire hit_exc = (adr_i == `FPEM_ADDR_EXC);
    wire hit_f0 = (adr_i == `FPEM_ADDR_FEAT0);
    wire hit_f1 = (adr_i == `FPEM_ADDR_FEAT1);
    wire hit_stat = (adr_i == `FPEM_ADDR_STAT);
    wire needs_priv = hit_exc || hit_f0 || hit_f1;
    wire deny = needs_priv && !priv;
    wire answered = ack_o || err_o;
    wire bus_fire = bus_req && answered;
    wire wr_exc = bus_fire && ack_o && we_i && hit_exc && sel_i[3];
    wire wr_stat = bus_fire && ack_o && we_i && hit_stat;

    wire [31:0] exc_word = {1'b0, exc_en, exc_vundef, 29'h0};
    wire [31:0] stat_word = {6'h0, dn, fz, 16'h0, flag_idc, 3'h0, flag_ufc, 2'h0, flag_ioc};
    wire [31:0] feat0_word = `FPEM_FEAT0_VAL;
    wire [31:0] feat1_word = `FPEM_FEAT1_VAL;
    wire [31:0] rd_word = hit_exc ? exc_word :
                          hit_f0 ? feat0_word :
                          hit_f1 ? feat1_word :
                          hit_stat ? stat_word : 32'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= bus_req && !answered && !deny;
            err_o <= bus_req && !answered && deny;
            dat_o <= (bus_req && !answered && !deny) ? rd_word : 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // undefined-instruction decision
    // ----------------------------------------------------------------
    wire iss_undef_dis = issue_valid && !exc_en && !issue.sysreg;
    wire iss_undef_vec = issue_valid && issue.vector && !issue.sysreg;
    wire iss_undef = iss_undef_dis || iss_undef_vec;
    wire any_undef = iss_undef || (err_o && bus_fire);
    wire next_vundef = iss_undef ? (iss_undef_vec && exc_en) : 1'b0;
    wire exec_ok = issue_valid && !iss_undef && !issue.sysreg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            exc_en <= 1'b0;
            exc_vundef <= 1'b0;
            undef_exc <= 1'b0;
        end else begin
            undef_exc <= iss_undef;
            if (wr_exc) begin
                exc_en <= dat_i[`FPEM_EXC_EN];
            end
            if (any_undef) begin
                exc_vundef <= next_vundef;
            end else if (wr_exc) begin
                exc_vundef <= dat_i[`FPEM_EXC_VUNDEF];
            end
        end
    end

    // ----------------------------------------------------------------
    // operand conditioning
    // ----------------------------------------------------------------
    wire flush_a = fz && issue.arith && f_sub(issue.dbl, issue.op_a);
    wire flush_b = fz && issue.arith && f_sub(issue.dbl, issue.op_b);
    wire snan_in = issue.arith && (f_snan(issue.dbl, issue.op_a) || f_snan(issue.dbl, issue.op_b));
    // flushed values are true signed zeros, so later exceptions behave as for zero
    wire [63:0] next_a = flush_a ? f_zero(issue.dbl, issue.op_a) : issue.op_a;
    wire [63:0] next_b = flush_b ? f_zero(issue.dbl, issue.op_b) : issue.op_b;
    wire set_idc = exec_ok && (flush_a || flush_b);
    wire set_ioc = exec_ok && dn && snan_in;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ops_valid <= 1'b0;
            ops <= '0;
        end else begin
            ops_valid <= exec_ok;
            ops <= {issue.dbl, issue.arith, next_a, next_b};
        end
    end

    // ----------------------------------------------------------------
    // result rewriting
    // ----------------------------------------------------------------
    wire res_flush = res_valid && fz && res.arith && res.tiny;
    wire res_is_nan = res.nan_in || f_nan(res.dbl, res.value);
    wire res_dnan = res_valid && dn && res.arith && res_is_nan;
    wire [63:0] dnan_word = res.dbl ? `FPEM_DNAN_DBL : {32'h0, `FPEM_DNAN_SGL};
    wire [63:0] next_out = res_dnan ? dnan_word :
                           res_flush ? f_zero(res.dbl, res.value) : res.value;
    wire set_ufc = res_flush;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_value <= 64'h0;
        end else begin
            out_valid <= res_valid;
            out_value <= next_out;
        end
    end

    // ----------------------------------------------------------------
    // status mode bits and sticky flags, set beats clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fz <= 1'b0;
            dn <= 1'b0;
            flag_idc <= 1'b0;
            flag_ufc <= 1'b0;
            flag_ioc <= 1'b0;
        end else begin
            if (wr_stat && sel_i[3]) begin
                dn <= dat_i[`FPEM_STAT_DNAN];
                fz <= dat_i[`FPEM_STAT_FZ];
            end
            flag_idc <= set_idc || ((wr_stat && sel_i[0]) ? dat_i[`FPEM_STAT_IDC] : flag_idc);
            flag_ufc <= set_ufc || ((wr_stat && sel_i[0]) ? dat_i[`FPEM_STAT_UFC] : flag_ufc);
            flag_ioc <= set_ioc || ((wr_stat && sel_i[0]) ? dat_i[`FPEM_STAT_IOC] : flag_ioc);
        end
    end

    assign fp_enable = exc_en;
    assign flush_zero_bit = fz;
    assign default_nan_bit = dn;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // only the cycle in which the request is first seen, not while it waits for release
    sequence s_unpriv_write;
        bus_req && !answered && we_i && hit_exc && !priv;
    endsequence

    sequence s_err_answer;
        !ack_o ##1 err_o;
    endsequence

    unpriv_keep_a: assert property (s_unpriv_write |-> s_err_answer ##1 $stable(exc_en))
        else $error("unprivileged write reached exception control");
    disabled_undef_a: assert property (issue_valid && !exc_en && !issue.sysreg
        |=> undef_exc && !ops_valid)
        else $error("disabled unit executed an instruction");
    feat_priv_a: assert property (bus_req && (hit_f0 || hit_f1) && !priv && !answered
        |=> err_o && !ack_o)
        else $error("feature register reached without privilege");
    vundef_set_a: assert property (issue_valid && exc_en && issue.vector && !issue.sysreg
        |=> exc_vundef && undef_exc)
        else $error("vector undefined flag not set");
    feat0_read_a: assert property (bus_req && !we_i && hit_f0 && priv && !answered
        |=> ack_o && dat_o == 32'h1011_0201)
        else $error("feature 0 read wrong");
    exc_reserved_a: assert property (ack_o && hit_exc && !we_i
        |-> dat_o[31] == 1'b0 && dat_o[28:0] == 29'h0)
        else $error("reserved exception bits not zero");
    flush_zero_a: assert property (exec_ok && fz && issue.arith && f_sub(issue.dbl, issue.op_a)
        |=> (ops.dbl ? (ops.op_a[62:0] == 63'h0) : (ops.op_a[30:0] == 31'h0)) && flag_idc)
        else $error("subnormal input not flushed");
    flush_sign_a: assert property (exec_ok && flush_a && !issue.dbl
        |=> ops.op_a[31] == $past(issue.op_a[31]))
        else $error("flushed operand lost its sign");
    idc_set_a: assert property (set_idc |=> flag_idc)
        else $error("input flush did not set input subnormal flag");
    ufc_set_a: assert property (set_ufc |=> flag_ufc)
        else $error("result flush did not set underflow flag");
    feat1_read_a: assert property (bus_req && !we_i && hit_f1 && priv && !answered
        |=> ack_o && dat_o == 32'h0000_0011)
        else $error("feature 1 read wrong");
    move_keep_a: assert property (exec_ok && !issue.arith |=> ops.op_a == $past(issue.op_a))
        else $error("non-arithmetic operand altered");
    tiny_flush_a: assert property (res_valid && fz && res.arith && res.tiny && !res_dnan
        |=> ($past(res.dbl) ? (out_value[62:0] == 63'h0) : (out_value[30:0] == 31'h0))
        && flag_ufc)
        else $error("tiny result not flushed");
    dnan_out_a: assert property (res_valid && dn && res.arith && res.dbl && res.nan_in
        |=> out_value == 64'h7FF8_0000_0000_0000)
        else $error("default nan not returned");
    dnan_sgl_a: assert property (res_valid && dn && res.arith && !res.dbl && res.nan_in
        |=> out_value == 64'h0000_0000_7FC0_0000)
        else $error("single default nan wrong");
    nonarith_keep_a: assert property (res_valid && !res.arith && !fz
        |=> out_value == $past(res.value))
        else $error("non-arithmetic nan fraction altered");
    exc_write_a: assert property (wr_exc |=> exc_en == $past(dat_i[30]))
        else $error("privileged enable write lost");
    snan_ioc_a: assert property (set_ioc |=> flag_ioc)
        else $error("signaling nan did not set invalid flag");
    plain_pass_a: assert property (res_valid && !fz && !dn |=> out_value == $past(res.value))
        else $error("result rewritten with both modes off");

endmodule // fpem_top

// ### fpem_dpath_model.sv
// Purpose: behavioural datapath that answers conditioned operands with a result
// Assumes: one operation in flight at a time
// Notes: result echoes operand a; value lines toggle while no result is offered
`timescale 1ns/10ps

module fpem_dpath_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic force_tiny,
    input wire logic ops_valid,
    input wire fpem_pkg::fpem_operands_t ops,
    output logic res_valid,
    output fpem_pkg::fpem_result_t res
);
    fpem_pkg::fpem_operands_t held;
    logic busy;
    logic [1:0] cnt;
    wire logic [63:0] a = held.op_a;
    wire logic exp_zero = held.dbl ? (a[62:52] == 11'h000) : (a[30:23] == 8'h00);
    wire logic exp_ones = held.dbl ? (a[62:52] == 11'h7FF) : (a[30:23] == 8'hFF);
    wire logic frac_nz = held.dbl ? (a[51:0] != 52'h0) : (a[22:0] != 23'h0);
    wire logic tiny = force_tiny | (exp_zero & frac_nz);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= 2'h0;
            held <= '0;
            res_valid <= 1'b0;
            res <= '0;
        end else begin
            res_valid <= 1'b0;
            res.value <= ~res.value;
            if (ops_valid) begin
                held <= ops;
                busy <= 1'b1;
                cnt <= slow ? 2'h3 : 2'h0;
            end else if (busy && cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
            end else if (busy) begin
                busy <= 1'b0;
                res_valid <= 1'b1;
                res <= {held.dbl, held.arith, tiny, exp_ones & frac_nz, a};
            end
        end
    end
endmodule // fpem_dpath_model

// ### fpu_exception_feature_modes_bench.sv
// Purpose: self-checking bench for the fpu exception, feature and mode block
// Assumes: bench stands in for the core pipeline and the bus master
// Notes: datapath answers come from fpem_dpath_model
`timescale 1ns/10ps

module fpu_exception_feature_modes_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, priv = 1'b1;
    logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, err_o, undef_exc, ops_valid, res_valid, out_valid, e, u;
    logic fp_enable, flush_zero_bit, default_nan_bit, issue_valid = 1'b0;
    logic slow = 1'b0, force_tiny = 1'b0;
    fpem_pkg::fpem_issue_t issue = '0;
    fpem_pkg::fpem_operands_t ops;
    fpem_pkg::fpem_result_t res;
    logic [63:0] out_value, o, r;
    int n_errors = 0, n_compared = 0;

    always #2.5 clk = ~clk;

    fpem_top dut_u (.clk(clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .err_o(err_o), .priv(priv), .issue_valid(issue_valid), .issue(issue),
        .undef_exc(undef_exc), .ops_valid(ops_valid), .ops(ops), .res_valid(res_valid),
        .res(res), .out_valid(out_valid), .out_value(out_value), .fp_enable(fp_enable),
        .flush_zero_bit(flush_zero_bit), .default_nan_bit(default_nan_bit));

    fpem_dpath_model dp_u (.clk(clk), .rst_n(rst_n), .slow(slow), .force_tiny(force_tiny),
        .ops_valid(ops_valid), .ops(ops), .res_valid(res_valid), .res(res));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wb(input logic w, input logic p, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        priv <= p;
        adr_i <= a;
        dat_i <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (ack_o === 1'b1 || err_o === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            final_report();
        end
        rd = dat_o;
        e = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic rdx(input logic p, input logic [3:0] a, input logic [31:0] m,
                       input logic [31:0] x, input logic xe);
        wb(1'b0, p, a, 32'h0);
        chk(rd & m, x);
        chk(e, xe);
    endtask

    // k is {sysreg, vector, arith, dbl}
    task automatic op(input logic [3:0] k, input logic [63:0] a);
        int i;
        @(posedge clk);
        issue_valid <= 1'b1;
        issue <= {k, a, 64'h0};
        @(posedge clk);
        issue_valid <= 1'b0;
        #1;
        u = undef_exc;
        o = ops.op_a;
        r = 64'h0;
        if (ops_valid !== 1'b1) return;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (out_valid === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            final_report();
        end
        r = out_value;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        $display("test reset values");
        chk(fp_enable, 1'b0);
        chk({flush_zero_bit, default_nan_bit}, 2'h0);
        rdx(1'b1, 4'h0, 32'hFFFF_FFFF, 32'h0, 1'b0);
        rdx(1'b1, 4'hC, 32'hFFFF_FFFF, 32'h0, 1'b0);
        rdx(1'b1, 4'h4, 32'hF0FF_FF0F, 32'h1011_0201, 1'b0);
        rdx(1'b1, 4'h8, 32'hFFFF_FFFF, 32'h0000_0011, 1'b0);
        $display("test privilege");
        wb(1'b1, 1'b0, 4'h0, 32'h4000_0000);
        chk(e, 1'b1);
        rdx(1'b1, 4'h0, 32'hFFFF_FFFF, 32'h0, 1'b0);
        rdx(1'b0, 4'h0, 32'hFFFF_FFFF, 32'h0, 1'b1);
        rdx(1'b0, 4'h4, 32'hFFFF_FFFF, 32'h0, 1'b1);
        rdx(1'b0, 4'h8, 32'hFFFF_FFFF, 32'h0, 1'b1);
        rdx(1'b1, 4'h2, 32'hFFFF_FFFF, 32'h0, 1'b0);
        $display("test enable and reserved bits");
        op(4'h2, 64'h3F80_0000);
        chk(u, 1'b1);
        op(4'h8, 64'h0);
        chk(u, 1'b0);
        wb(1'b1, 1'b1, 4'h0, 32'hFFFF_FFFF);
        rdx(1'b1, 4'h0, 32'hFFFF_FFFF, 32'h6000_0000, 1'b0);
        wb(1'b1, 1'b1, 4'h8, 32'h0);
        rdx(1'b1, 4'h8, 32'hFFFF_FFFF, 32'h0000_0011, 1'b0);
        wb(1'b1, 1'b1, 4'h0, 32'h4000_0000);
        chk(fp_enable, 1'b1);
        op(4'h2, 64'h3F80_0000);
        chk(u, 1'b0);
        $display("test vector flag");
        op(4'h6, 64'h3F80_0000);
        chk(u, 1'b1);
        rdx(1'b1, 4'h0, 32'hFFFF_FFFF, 32'h6000_0000, 1'b0);
        wb(1'b1, 1'b1, 4'h0, 32'h2000_0000);
        op(4'h2, 64'h3F80_0000);
        chk(u, 1'b1);
        rdx(1'b1, 4'h0, 32'hFFFF_FFFF, 32'h0, 1'b0);
        wb(1'b1, 1'b1, 4'h0, 32'h4000_0000);
        $display("test flush to zero");
        wb(1'b1, 1'b1, 4'hC, 32'h0100_0000);
        op(4'h2, 64'h8000_0001);
        chk(o[31:0], 32'h8000_0000);
        rdx(1'b1, 4'hC, 32'hFFFF_FFFF, 32'h0100_0080, 1'b0);
        wb(1'b1, 1'b1, 4'hC, 32'h0100_0000);
        op(4'h0, 64'h1);
        chk(o[31:0], 32'h1);
        slow <= 1'b1;
        force_tiny <= 1'b1;
        op(4'h2, 64'h3F80_0000);
        chk(r[31:0], 32'h0);
        force_tiny <= 1'b0;
        rdx(1'b1, 4'hC, 32'hFFFF_FFFF, 32'h0100_0008, 1'b0);
        $display("test default nan");
        wb(1'b1, 1'b1, 4'hC, 32'h0200_0000);
        op(4'h2, 64'h7F80_0001);
        chk(r[31:0], 32'h7FC0_0000);
        rdx(1'b1, 4'hC, 32'hFFFF_FFFF, 32'h0200_0001, 1'b0);
        op(4'h0, 64'h7F80_0001);
        chk(r[31:0], 32'h7F80_0001);
        op(4'h3, 64'h7FF0_0000_0000_0001);
        chk(r, 64'h7FF8_0000_0000_0000);
        $display("test full compliance");
        wb(1'b1, 1'b1, 4'hC, 32'h0);
        op(4'h2, 64'h1);
        chk(o[31:0], 32'h1);
        op(4'h2, 64'h7FC0_0001);
        chk(r[31:0], 32'h7FC0_0001);
        final_report();
    end
endmodule // fpu_exception_feature_modes_bench
